// file: common/dcs_pkg.sv
package dcs_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] STATUS_OFFSET  = 8'h00;
	localparam logic [7:0] CONTROL_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;

	// Status field positions
	localparam int READY_BIT    = 31;
	localparam int DONE_OK_BIT  = 23;
	localparam int DONE_ERR_BIT = 22;
	localparam int SRC_BIT      = 20;
	localparam int DST_BIT      = 19;
	localparam int SETUP_BIT    = 18;

	// Control field positions
	localparam int GO_BIT        = 0;
	localparam int OK_IEN_BIT    = 1;
	localparam int ERR_IEN_BIT   = 2;

	// Event bit positions and width of the sticky event register
	localparam int EV_OK    = 0;
	localparam int EV_ERR   = 1;
	localparam int EV_REFUS = 2;
	localparam int EV_W     = 3;

	// Reset values
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// Flag group carried between processes
	typedef struct packed {
		logic ready;
		logic done_ok;
		logic done_err;
		logic src;
		logic dst;
		logic setup;
	} dcs_flags_type;

	// Events reported by the transfer engine
	typedef struct packed {
		logic term_ok;
		logic term_err;
		logic src_fault;
		logic dst_fault;
		logic setup_fault;
	} dcs_engine_type;

endpackage

// file: rtl/dcs_event_irq.sv
`timescale 1ns/1ps
// Sticky event bits with mask and one level interrupt
module dcs_event_irq #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	// Events and software access
	input  wire logic [WIDTH-1:0] event_in,
	input  wire logic             clear_we_in,
	input  wire logic             mask_we_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	// State
	output logic      [WIDTH-1:0] status_out,
	output logic      [WIDTH-1:0] mask_out,
	output logic                  irq_out
);

	logic [WIDTH-1:0] status_q, status_d, mask_q, mask_d;
	logic             irq_q, irq_d;

	initial begin
		if (WIDTH < 1) $error("WIDTH must be at least one");
	end

	// Set wins over a write-one clear
	always_comb begin
		status_d = status_q;
		mask_d   = mask_q;
		if (clear_we_in) status_d = status_d & ~wdata_in;
		status_d = status_d | event_in;
		if (mask_we_in) mask_d = wdata_in;
		irq_d = |(status_d & mask_d);
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_q <= '0;
			mask_q   <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

	assign status_out = status_q;
	assign mask_out   = mask_q;
	assign irq_out    = irq_q;

	a_irq_level: assert property (@(posedge clock_in) disable iff (!resetn_in)
		irq_q == |(status_q & mask_q))
		else $error("Interrupt level disagrees with status and mask");

endmodule

// file: rtl/dcs_channel_status.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Contract
// - Ready flag reflects channel Ready state
// - Normal end sets done_ok, optional interrupt
// - Writing zero clears done_ok and interrupt (only done_ok_irq_out here; irq_out waits for a write-one clear)
// - Go with done_ok set is an error
// - Error end sets done_error, optional interrupt
// - Zero to done_error clears all faults
// - Go with done_error set is an error
// - Source read bus error sets source fault
// - Destination write error sets dest fault
// - Configuration error sets setup fault
// - All status flags zero after reset
module dcs_channel_status (
	// Clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     resetn_in,
	// Register port
	input  wire logic [7:0]               addr_in,
	input  wire logic [31:0]              wdata_in,
	input  wire logic                     write_in,
	input  wire logic                     read_in,
	output logic      [31:0]              rdata_out,
	// Transfer engine events
	input  wire dcs_pkg::dcs_engine_type  engine_in,
	// Channel state to the engine
	output logic                          ready_out,
	output logic                          start_out,
	output logic                          start_refused_out,
	// Interrupts
	output logic                          done_ok_irq_out,
	output logic                          done_err_irq_out,
	output logic                          irq_out
);

	dcs_pkg::dcs_flags_type flags_q, flags_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ok_ien_q, ok_ien_d, err_ien_q, err_ien_d;
	logic        start_q, start_d, refused_q, refused_d;
	logic        ok_irq_q, ok_irq_d, err_irq_q, err_irq_d;
	logic [dcs_pkg::EV_W-1:0] ev_status, ev_mask, ev_set;
	logic        ev_irq;
	logic        wr_status, wr_control, go_req, any_fault, term_err;

	// Address decode helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_status  = write_in && hit(addr_in, dcs_pkg::STATUS_OFFSET);
	assign wr_control = write_in && hit(addr_in, dcs_pkg::CONTROL_OFFSET);
	assign go_req     = wr_control && wdata_in[dcs_pkg::GO_BIT];
	assign any_fault  = engine_in.src_fault | engine_in.dst_fault | engine_in.setup_fault;
	assign term_err   = engine_in.term_err | any_fault;

	// Status flag next state
	always_comb begin
		flags_d = flags_q;
		if (wr_status && !wdata_in[dcs_pkg::DONE_OK_BIT]) flags_d.done_ok = 1'b0;
		// zero written clears error and causes
		if (wr_status && !wdata_in[dcs_pkg::DONE_ERR_BIT]) begin
			flags_d.done_err = 1'b0;
			flags_d.src      = 1'b0;
			flags_d.dst      = 1'b0;
			flags_d.setup    = 1'b0;
		end
		// ones written leave flags alone (no set path from writes)
		if (start_d) flags_d.ready = 1'b1;
		// normal end sets done_ok, set wins
		if (engine_in.term_ok) flags_d.done_ok = 1'b1;
		if (engine_in.src_fault) flags_d.src = 1'b1;
		if (engine_in.dst_fault) flags_d.dst = 1'b1;
		if (engine_in.setup_fault) flags_d.setup = 1'b1;
		if (term_err) flags_d.done_err = 1'b1;
		if (engine_in.term_ok || term_err) flags_d.ready = 1'b0;
	end

	// Control and start handling
	always_comb begin
		ok_ien_d  = ok_ien_q;
		err_ien_d = err_ien_q;
		start_d   = 1'b0;
		refused_d = 1'b0;
		if (wr_control) begin
			ok_ien_d  = wdata_in[dcs_pkg::OK_IEN_BIT];
			err_ien_d = wdata_in[dcs_pkg::ERR_IEN_BIT];
		end
		// go refused while a completion flag stands
		if (go_req) begin
			if (flags_q.done_ok || flags_q.done_err) refused_d = 1'b1;
			else start_d = 1'b1;
		end
	end

	// Per-flag interrupts follow next flag state
	always_comb begin
		ok_irq_d  = flags_d.done_ok && ok_ien_d;
		err_irq_d = flags_d.done_err && err_ien_d;
	end

	// Read data, valid the cycle after the strobe
	always_comb begin
		rdata_d = dcs_pkg::ZERO_WORD;
		if (read_in) begin
			case (addr_in)
				dcs_pkg::STATUS_OFFSET: begin
					rdata_d[dcs_pkg::READY_BIT]    = flags_q.ready;
					rdata_d[dcs_pkg::DONE_OK_BIT]  = flags_q.done_ok;
					rdata_d[dcs_pkg::DONE_ERR_BIT] = flags_q.done_err;
					rdata_d[dcs_pkg::SRC_BIT]      = flags_q.src;
					rdata_d[dcs_pkg::DST_BIT]      = flags_q.dst;
					rdata_d[dcs_pkg::SETUP_BIT]    = flags_q.setup;
				end
				dcs_pkg::CONTROL_OFFSET: begin
					rdata_d[dcs_pkg::OK_IEN_BIT]  = ok_ien_q;
					rdata_d[dcs_pkg::ERR_IEN_BIT] = err_ien_q;
				end
				dcs_pkg::IRQ_STAT_OFFSET: begin
					rdata_d[dcs_pkg::EV_W-1:0] = ev_status;
				end
				dcs_pkg::IRQ_MASK_OFFSET: begin
					rdata_d[dcs_pkg::EV_W-1:0] = ev_mask;
				end
				default: begin
					rdata_d = dcs_pkg::ZERO_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_q   <= '0;
			rdata_q   <= dcs_pkg::ZERO_WORD;
			ok_ien_q  <= 1'b0;
			err_ien_q <= 1'b0;
			start_q   <= 1'b0;
			refused_q <= 1'b0;
			ok_irq_q  <= 1'b0;
			err_irq_q <= 1'b0;
		end else begin
			flags_q   <= flags_d;
			rdata_q   <= rdata_d;
			ok_ien_q  <= ok_ien_d;
			err_ien_q <= err_ien_d;
			start_q   <= start_d;
			refused_q <= refused_d;
			ok_irq_q  <= ok_irq_d;
			err_irq_q <= err_irq_d;
		end
	end

	// Events for the sticky interrupt register
	always_comb begin
		ev_set = '0;
		ev_set[dcs_pkg::EV_OK]    = engine_in.term_ok;
		ev_set[dcs_pkg::EV_ERR]   = term_err;
		ev_set[dcs_pkg::EV_REFUS] = refused_d;
	end

	dcs_event_irq #(
		.WIDTH(dcs_pkg::EV_W)
	) dcs_event_irq_i (
		.clock_in   (clock_in),
		.resetn_in  (resetn_in),
		.event_in   (ev_set),
		.clear_we_in(write_in && hit(addr_in, dcs_pkg::IRQ_STAT_OFFSET)),
		.mask_we_in (write_in && hit(addr_in, dcs_pkg::IRQ_MASK_OFFSET)),
		.wdata_in   (wdata_in[dcs_pkg::EV_W-1:0]),
		.status_out (ev_status),
		.mask_out   (ev_mask),
		.irq_out    (ev_irq)
	);

	assign rdata_out         = rdata_q;
	assign ready_out         = flags_q.ready;
	assign start_out         = start_q;
	assign start_refused_out = refused_q;
	assign done_ok_irq_out   = ok_irq_q;
	assign done_err_irq_out  = err_irq_q;
	assign irq_out           = ev_irq;

	a_ok_sets: assert property (@(posedge clock_in) disable iff (!resetn_in)
		engine_in.term_ok |=> flags_q.done_ok && !flags_q.ready)
		else $error("Normal end did not set done_ok");

	// zero write clears done_ok without new end
	a_ok_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && !wdata_in[dcs_pkg::DONE_OK_BIT] && !engine_in.term_ok
		|=> !flags_q.done_ok && !done_ok_irq_out)
		else $error("done_ok not cleared by zero write");

	// go with a flag set never starts
	sequence s_go_blocked;
		go_req && (flags_q.done_ok || flags_q.done_err);
	endsequence
	a_go_refused: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_go_blocked |=> start_refused_out && !start_out)
		else $error("Start accepted with completion flag set");

	a_err_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && !wdata_in[dcs_pkg::DONE_ERR_BIT] && !term_err
		|=> !flags_q.done_err && !flags_q.src && !flags_q.dst && !flags_q.setup)
		else $error("Error flags not cleared together");

	a_one_ignored: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && !flags_q.done_ok && !engine_in.term_ok |=> !flags_q.done_ok)
		else $error("Written one set done_ok");

	a_fault_sets: assert property (@(posedge clock_in) disable iff (!resetn_in)
		engine_in.src_fault |=> flags_q.src && flags_q.done_err && !flags_q.ready)
		else $error("Source fault not recorded");

	a_dst_sets: assert property (@(posedge clock_in) disable iff (!resetn_in)
		engine_in.dst_fault |=> flags_q.dst && flags_q.done_err)
		else $error("Destination fault not recorded");

	a_setup_sets: assert property (@(posedge clock_in) disable iff (!resetn_in)
		engine_in.setup_fault |=> flags_q.setup && flags_q.done_err)
		else $error("Configuration fault not recorded");

	// per-flag interrupt follows flag and enable
	a_err_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
		done_err_irq_out == (flags_q.done_err && err_ien_q))
		else $error("Error interrupt mismatch");

	// normal end interrupt follows flag and enable
	a_ok_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
		done_ok_irq_out == (flags_q.done_ok && ok_ien_q))
		else $error("Normal end interrupt mismatch");

	// one written keeps a set done_ok
	a_ok_one_kept: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && wdata_in[dcs_pkg::DONE_OK_BIT] && flags_q.done_ok |=> flags_q.done_ok)
		else $error("Written one cleared done_ok");

	// one written keeps a set done_error
	a_err_one_kept: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && wdata_in[dcs_pkg::DONE_ERR_BIT] && flags_q.done_err |=> flags_q.done_err)
		else $error("Written one cleared done_error");

	a_err_one_ignored: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && !flags_q.done_err && !term_err |=> !flags_q.done_err)
		else $error("Written one set done_error");

	// error end without cause sets done_error
	a_err_end_sets: assert property (@(posedge clock_in) disable iff (!resetn_in)
		engine_in.term_err |=> flags_q.done_err && !flags_q.ready)
		else $error("Error end not recorded");

	sequence s_go_free;
		go_req && !(flags_q.done_ok || flags_q.done_err) && !engine_in.term_ok && !term_err;
	endsequence
	a_go_starts: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_go_free |=> start_out && ready_out && !start_refused_out)
		else $error("Free go did not start the channel");

	a_ready_holds: assert property (@(posedge clock_in) disable iff (!resetn_in)
		flags_q.ready && !engine_in.term_ok && !term_err |=> flags_q.ready)
		else $error("Ready flag dropped without termination");

	// Ready state needs an accepted go
	a_ready_waits: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!flags_q.ready && !go_req |=> !flags_q.ready)
		else $error("Ready flag rose without a go");

	a_err_irq_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr_status && !wdata_in[dcs_pkg::DONE_ERR_BIT] && !term_err |=> !done_err_irq_out)
		else $error("Error interrupt not withdrawn");

	// source fault flag only on a source fault
	a_src_no_spurious: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!flags_q.src && !engine_in.src_fault |=> !flags_q.src)
		else $error("Source fault flag set without cause");

	// destination fault flag only on its fault
	a_dst_no_spurious: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!flags_q.dst && !engine_in.dst_fault |=> !flags_q.dst)
		else $error("Destination fault flag set without cause");

	// setup fault flag only on its fault
	a_setup_no_spurious: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!flags_q.setup && !engine_in.setup_fault |=> !flags_q.setup)
		else $error("Setup fault flag set without cause");

	// status read shows the flags of the strobe cycle
	a_status_read: assert property (@(posedge clock_in) disable iff (!resetn_in)
		read_in && addr_in == dcs_pkg::STATUS_OFFSET
		|=> rdata_out[dcs_pkg::READY_BIT] == $past(flags_q.ready)
		&& rdata_out[dcs_pkg::DONE_OK_BIT] == $past(flags_q.done_ok)
		&& rdata_out[dcs_pkg::DONE_ERR_BIT] == $past(flags_q.done_err))
		else $error("Status read data disagrees with flags");

endmodule

// file: verification/test_dcs_channel_status.sv
`timescale 1ns/1ps
module test_dcs_channel_status;
	// Short aliases for register offsets
	localparam logic [7:0] ST = dcs_pkg::STATUS_OFFSET;
	localparam logic [7:0] CT = dcs_pkg::CONTROL_OFFSET;
	localparam logic [7:0] IS = dcs_pkg::IRQ_STAT_OFFSET;
	localparam logic [7:0] IM = dcs_pkg::IRQ_MASK_OFFSET;
	// Design connections
	logic                    clock_in;
	logic                    resetn_in;
	logic [7:0]              addr_in;
	logic [31:0]             wdata_in;
	logic                    write_in;
	logic                    read_in;
	logic [31:0]             rdata_out;
	dcs_pkg::dcs_engine_type engine_in;
	logic                    ready_out;
	logic                    start_out;
	logic                    start_refused_out;
	logic                    done_ok_irq_out;
	logic                    done_err_irq_out;
	logic                    irq_out;
	// Bench bookkeeping
	logic [31:0]             exp_q[$];
	logic [31:0]             fail_count;
	logic [31:0]             n_compared;
	logic [31:0]             starts;
	logic [31:0]             refusals;
	logic [31:0]             seed;
	logic                    rd_d;

	dcs_channel_status dcs_channel_status_i (.clock_in(clock_in), .resetn_in(resetn_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
		.rdata_out(rdata_out), .engine_in(engine_in), .ready_out(ready_out),
		.start_out(start_out), .start_refused_out(start_refused_out),
		.done_ok_irq_out(done_ok_irq_out), .done_err_irq_out(done_err_irq_out),
		.irq_out(irq_out));

	// Free running clock
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus cycle; strobes stay up until idle or the next cycle
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		write_in <= w;
		read_in <= r;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clock_in);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		op(1'b0, 1'b1, a, 32'h0000_0000);
	endtask

	task automatic idle(input int n);
		write_in <= 1'b0;
		read_in <= 1'b0;
		engine_in <= dcs_pkg::dcs_engine_type'(5'h00);
		repeat (n) @(posedge clock_in);
	endtask

	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared != 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Read data checker and pulse counters
	always @(posedge clock_in) begin
		if (rd_d) begin
			cmp_word(rdata_out, exp_q.pop_front());
		end
		if (start_out === 1'b1) starts = starts + 1;
		if (start_refused_out === 1'b1) refusals = refusals + 1;
		rd_d <= read_in;
	end

	// Watchdog against a hung run
	initial begin
		#200_000;
		fail_count = fail_count + 1;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{resetn_in, write_in, read_in, rd_d} = 4'h0;
		addr_in = 8'h00;
		wdata_in = 32'h0000_0000;
		engine_in = dcs_pkg::dcs_engine_type'(5'h00);
		{fail_count, n_compared, starts, refusals} = {4{32'h0000_0000}};
		seed = 32'h0000_6c5a;
		repeat (2) @(posedge clock_in);
		resetn_in <= 1'b1;
		@(posedge clock_in);
		rd(ST, 32'h0000_0000);
		rd(CT, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		idle(2);
		cmp_word({31'h0, ready_out | irq_out}, 32'h0000_0000);
		op(1'b1, 1'b0, IM, 32'h0000_0007);
		op(1'b1, 1'b0, CT, 32'h0000_0007);
		idle(3);
		cmp_word({31'h0, ready_out}, 32'h0000_0001);
		rd(ST, 32'h8000_0000);
		read_in <= 1'b0;
		engine_in <= dcs_pkg::dcs_engine_type'(5'h10);
		@(posedge clock_in);
		idle(3);
		rd(ST, 32'h0080_0000);
		op(1'b1, 1'b0, CT, 32'h0000_0007);
		idle(3);
		cmp_word({starts[15:0], refusals[15:0]}, 32'h0001_0001);
		cmp_word({30'h0, done_ok_irq_out, irq_out}, 32'h0000_0003);
		rd(CT, 32'h0000_0006);
		rd(IS, 32'h0000_0005);
		rd(IM, 32'h0000_0007);
		seed = lfsr(seed);
		op(1'b1, 1'b0, ST, (seed | 32'h00C0_0000) & 32'hFFDF_FFF8);
		idle(2);
		rd(ST, 32'h0080_0000);
		op(1'b1, 1'b0, ST, 32'h0000_0000);
		op(1'b1, 1'b0, IS, 32'h0000_0007);
		idle(3);
		rd(ST, 32'h0000_0000);
		idle(2);
		cmp_word({30'h0, done_ok_irq_out, irq_out}, 32'h0000_0000);
		// Each fault kind, then a plain error end; the setup fault runs masked
		for (int i = 0; i < 4; i++) begin
			op(1'b1, 1'b0, IM, (i == 2) ? 32'h0000_0000 : 32'h0000_0007);
			op(1'b1, 1'b0, CT, 32'h0000_0007);
			idle(3);
			engine_in <= dcs_pkg::dcs_engine_type'((i == 3) ? 5'h08 : 5'h04 >> i);
			@(posedge clock_in);
			idle(3);
			rd(ST, 32'h0040_0000 | ((32'h0010_0000 >> i) & 32'h001C_0000));
			op(1'b1, 1'b0, CT, 32'h0000_0007);
			idle(3);
			cmp_word({starts[15:0], refusals[15:0]}, {16'(2 + i), 16'(2 + i)});
			cmp_word({29'h0, ready_out, done_err_irq_out, irq_out}, {31'h0000_0001, i != 2});
			op(1'b1, 1'b0, ST, 32'h0000_0000);
			op(1'b1, 1'b0, IS, 32'h0000_0007);
			idle(3);
			rd(ST, 32'h0000_0000);
			idle(2);
			cmp_word({30'h0, done_err_irq_out, irq_out}, 32'h0000_0000);
		end
		idle(2);
		report_and_stop();
	end
endmodule
